/* File: hdl/dbgct_top.sv */
`timescale 1ns/1ps
`default_nettype none

module dbgct_top #(
    parameter int DEPTH = 64
) (
    input  wire logic                     mclk,
    input  wire logic                     reset_n,
    input  wire dbgct_pkg::dbgct_bus_t    cpu_bus,
    input  wire dbgct_pkg::dbgct_exec_t   exec_in,
    input  wire logic [dbgct_pkg::AW-1:0] awaddr,
    input  wire logic                     awvalid,
    output logic                          awready,
    input  wire logic [31:0]              wdata,
    input  wire logic [3:0]               wstrb,
    input  wire logic                     wvalid,
    output logic                          wready,
    output logic [1:0]                    bresp,
    output logic                          bvalid,
    input  wire logic                     bready,
    input  wire logic [dbgct_pkg::AW-1:0] araddr,
    input  wire logic                     arvalid,
    output logic                          arready,
    output logic [31:0]                   rdata,
    output logic [1:0]                    rresp,
    output logic                          rvalid,
    input  wire logic                     rready,
    output logic [dbgct_pkg::N_CMP-1:0]   seq_advance,
    output logic                          breakpoint,
    output logic                          armed,
    output logic                          irq
);
    import dbgct_pkg::*;

    localparam int PW = $clog2(DEPTH);

    dbgct_cmp_ctl_t      ctl [N_CMP];
    logic [PC_W-1:0]     cadr [N_CMP];
    logic [PC_W-1:0]     tag_addr [N_CMP];
    logic [DATA_W-1:0]   cdat;
    logic [N_CMP-1:0]    tag_pend, fire, brk_bits;
    logic                bp_en, trace_en, sess_end, disarm_now, arm_start, wr_fire;
    logic [AW-1:0]       aw_addr, wr_word;
    logic [31:0]         w_data, ctl1_new, rd_val;
    logic [3:0]          w_strb;
    dbgct_line_t         mem [DEPTH];
    dbgct_line_t         tr_wdata;
    logic [PW-1:0]       wptr, cur, rptr, tr_widx;
    logic [PW:0]         count;
    logic [1:0]          n;
    logic [PC_W-1:0]     acc, next_acc;
    logic [PC_W-1:INC_W] base_hi;
    logic                first, wrapped, tr_go, need_base, open_new, tr_adv, tr_we;
    logic                rd_take, rd_trace, rd_err;
    logic [EV_W-1:0]     ev, irq_stat, irq_mask, next_irq_stat;

    // Byte-lane merge of a write into a stored value
    function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] d, logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++)
            if (s[b])
                r[8*b +: 8] = d[8*b +: 8];
        return r;
    endfunction : merge

    function automatic logic [AW-1:0] word_of(logic [AW-1:0] a);
        return {a[AW-1:2], 2'h0};
    endfunction : word_of

    function automatic logic [PW-1:0] ptr_next(logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction : ptr_next

    // Address/direction/data compare for a comparator in immediate mode
    function automatic logic imm_match(dbgct_cmp_ctl_t c, logic [PC_W-1:0] a,
                                       logic [DATA_W-1:0] d, logic use_d, dbgct_bus_t bus);
        logic dir_ok;
        logic dat_ok;
        dir_ok = !c.direction_qualify_enable || (c.read_select == bus.rd);
        dat_ok = !use_d || ((bus.data != d) == c.data_mismatch_select);
        return c.comparator_on && bus.valid && (bus.addr == a) && dir_ok && dat_ok;
    endfunction : imm_match

    // Both comparators judged from the same cycle's inputs
    always_comb
    begin
        for (int i = 0; i < N_CMP; i++)
        begin
            brk_bits[i] = ctl[i].immediate_session_end;
            if (ctl[i].tag_select)
                fire[i] = ctl[i].comparator_on && tag_pend[i] && exec_in.valid
                          && (exec_in.pc == tag_addr[i]);
            else
                fire[i] = imm_match(ctl[i], cadr[i], cdat, i == 0, cpu_bus);
        end
    end

    // Tagging: mark a fetched opcode, fire when it executes
    always_ff @(posedge mclk)
    begin
        for (int i = 0; i < N_CMP; i++)
        begin
            if (!reset_n || !ctl[i].comparator_on || !ctl[i].tag_select)
            begin
                tag_pend[i] <= 1'b0;
                tag_addr[i] <= '0;
            end
            else if (cpu_bus.valid && cpu_bus.fetch && cpu_bus.addr == cadr[i])
            begin
                tag_pend[i] <= 1'b1;
                tag_addr[i] <= cpu_bus.addr;
            end
            else if (fire[i])
                tag_pend[i] <= 1'b0;
        end
    end

    // Write channel handshakes; write acts once both halves are held
    assign wr_fire  = !awready && !wready && !bvalid;
    assign wr_word  = word_of(aw_addr);
    assign ctl1_new = merge({29'h0, trace_en, bp_en, armed}, w_data, w_strb);
    assign arm_start = wr_fire && wr_word == OFS_CTRL1 && ctl1_new[CTL1_ARM] && !armed;
    assign sess_end  = armed && |(fire & brk_bits);
    assign disarm_now = sess_end
                        || (armed && wr_fire && wr_word == OFS_CTRL1 && !ctl1_new[CTL1_ARM]);

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            awready <= 1'b1;
            wready  <= 1'b1;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
            aw_addr <= '0;
            w_data  <= '0;
            w_strb  <= '0;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_addr <= awaddr;
                awready <= 1'b0;
            end
            if (wvalid && wready)
            begin
                w_data <= wdata;
                w_strb <= wstrb;
                wready <= 1'b0;
            end
            if (wr_fire)
            begin
                bvalid <= 1'b1;
                bresp  <= (wr_word > OFS_IRQ_MASK || wr_word == OFS_TSTAT) ? RESP_SLVERR : RESP_OKAY;
            end
            else if (bvalid && bready)
            begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // Configuration registers; mismatch select exists on comparator A only
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            ctl[0] <= CMP_CTL_RST;
            ctl[1] <= CMP_CTL_RST;
            cadr[0] <= '0;
            cadr[1] <= '0;
            cdat <= '0;
            bp_en <= 1'b0;
            trace_en <= 1'b0;
            irq_mask <= '0;
        end
        else if (wr_fire)
        begin
            if (wr_word == OFS_CTRL1)
            begin
                bp_en    <= ctl1_new[CTL1_BRK_EN];
                trace_en <= ctl1_new[CTL1_TRACE];
            end
            else if (wr_word == OFS_CMPA_CTL)
                ctl[0] <= 8'(merge({24'h0, ctl[0]}, w_data, w_strb) & 32'h3F);
            else if (wr_word == OFS_CMPB_CTL)
                ctl[1] <= 8'(merge({24'h0, ctl[1]}, w_data, w_strb) & 32'h3D);
            else if (wr_word == OFS_CMPA_ADR)
                cadr[0] <= PC_W'(merge({14'h0, cadr[0]}, w_data, w_strb));
            else if (wr_word == OFS_CMPA_DAT)
                cdat <= DATA_W'(merge({16'h0, cdat}, w_data, w_strb));
            else if (wr_word == OFS_CMPB_ADR)
                cadr[1] <= PC_W'(merge({14'h0, cadr[1]}, w_data, w_strb));
            else if (wr_word == OFS_IRQ_MASK)
                irq_mask <= EV_W'(merge({28'h0, irq_mask}, w_data, w_strb));
        end
    end

    // Session state, sequencer events and breakpoint pulse
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            armed       <= 1'b0;
            breakpoint  <= 1'b0;
            seq_advance <= '0;
        end
        else
        begin
            breakpoint  <= sess_end && bp_en;
            seq_advance <= armed ? fire : '0;
            if (arm_start)
                armed <= 1'b1;
            else if (disarm_now)
                armed <= 1'b0;
        end
    end

    // Compressed PC trace: one buffer write per executed opcode
    assign tr_go     = armed && trace_en && !disarm_now && exec_in.valid;
    assign open_new  = (n == INFO_BASE) || (n == INFO_THREE);
    assign need_base = first || exec_in.pc[PC_W-1:INC_W] != base_hi
                       || (open_new && wptr == '0);
    // Increment is the offset in the 64-address block, newest in higher bits
    assign next_acc  = (open_new ? '0 : acc)
                       | (PC_W'(exec_in.pc[INC_W-1:0]) << (INC_W * (open_new ? 0 : int'(n))));
    assign tr_adv    = tr_go && (need_base || open_new);

    always_comb
    begin
        tr_we   = tr_go;
        tr_widx = wptr;
        if (need_base)
            tr_wdata = {INFO_BASE, exec_in.pc};
        else if (open_new)
            tr_wdata = {INFO_ONE, next_acc};
        else
        begin
            tr_widx  = cur;
            tr_wdata = {n + INFO_ONE, next_acc};
        end
    end

    // Storage has no reset; only lines below the count are meaningful
    always_ff @(posedge mclk)
    begin
        if (tr_we)
            mem[tr_widx] <= tr_wdata;
    end

    always_ff @(posedge mclk)
    begin
        if (!reset_n || arm_start)
        begin
            wptr    <= '0;
            cur     <= '0;
            n       <= INFO_BASE;
            first   <= 1'b1;
            wrapped <= 1'b0;
            count   <= '0;
            acc     <= '0;
            base_hi <= '0;
        end
        else if (tr_go)
        begin
            first <= 1'b0;
            acc   <= next_acc;
            if (need_base)
            begin
                base_hi <= exec_in.pc[PC_W-1:INC_W];
                n       <= INFO_BASE;
            end
            else if (open_new)
            begin
                cur <= wptr;
                n   <= INFO_ONE;
            end
            else
                n <= n + INFO_ONE;
            if (tr_adv)
            begin
                wptr <= ptr_next(wptr);
                if (wptr == PW'(DEPTH - 1))
                    wrapped <= 1'b1;
                if (count != (PW + 1)'(DEPTH))
                    count <= count + (PW + 1)'(1);
            end
        end
    end

    // Read pointer: oldest line at disarm, then first-in first-out
    assign rd_take  = arvalid && arready;
    assign rd_trace = rd_take && word_of(araddr) == OFS_TRACE && !armed && araddr[1:0] == 2'h0;

    always_ff @(posedge mclk)
    begin
        if (!reset_n || arm_start)
            rptr <= '0;
        else if (disarm_now)
            rptr <= wrapped ? wptr : '0;
        else if (rd_trace)
            rptr <= ptr_next(rptr);
    end

    // Read decode; a locked or misaligned trace read gives zero
    always_comb
    begin
        rd_err = 1'b0;
        rd_val = '0;
        if (word_of(araddr) == OFS_CTRL1)
            rd_val = {29'h0, trace_en, bp_en, armed};
        else if (word_of(araddr) == OFS_CMPA_CTL)
            rd_val = {24'h0, ctl[0]};
        else if (word_of(araddr) == OFS_CMPB_CTL)
            rd_val = {24'h0, ctl[1]};
        else if (word_of(araddr) == OFS_CMPA_ADR)
            rd_val = {14'h0, cadr[0]};
        else if (word_of(araddr) == OFS_CMPA_DAT)
            rd_val = {16'h0, cdat};
        else if (word_of(araddr) == OFS_CMPB_ADR)
            rd_val = {14'h0, cadr[1]};
        else if (word_of(araddr) == OFS_TRACE)
            rd_val = (!armed && araddr[1:0] == 2'h0) ? 32'(mem[rptr]) : '0;
        else if (word_of(araddr) == OFS_TSTAT)
            rd_val = {8'h0, wrapped, 7'(count), 8'(rptr), 8'(wptr)};
        else if (word_of(araddr) == OFS_IRQ_STAT)
            rd_val = {28'h0, irq_stat};
        else if (word_of(araddr) == OFS_IRQ_MASK)
            rd_val = {28'h0, irq_mask};
        else
            rd_err = 1'b1;
    end

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= RESP_OKAY;
        end
        else if (rd_take)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_val;
            rresp   <= rd_err ? RESP_SLVERR : RESP_OKAY;
        end
        else if (rvalid && rready)
        begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // Sticky events; a new event wins over a write-one clear
    assign ev[EV_MATCH_A] = armed && fire[0];
    assign ev[EV_MATCH_B] = armed && fire[1];
    assign ev[EV_SESSION] = sess_end;
    assign ev[EV_WRAP]    = tr_adv && wptr == PW'(DEPTH - 1);

    always_comb
    begin
        next_irq_stat = irq_stat;
        if (wr_fire && wr_word == OFS_IRQ_STAT && w_strb[0])
            next_irq_stat = irq_stat & ~EV_W'(w_data);
        next_irq_stat = next_irq_stat | ev;
    end

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            irq_stat <= '0;
            irq      <= 1'b0;
        end
        else
        begin
            irq_stat <= next_irq_stat;
            irq      <= |(next_irq_stat & irq_mask);
        end
    end
endmodule : dbgct_top

`default_nettype wire

/* File: hdl/dbgct_pkg.sv */
package dbgct_pkg;
    // Widths of the core buses and of one trace line
    localparam int PC_W   = 18;
    localparam int DATA_W = 16;
    localparam int INC_W  = 6;
    localparam int AW     = 8;
    localparam int N_CMP  = 2;

    // Register byte offsets
    localparam logic [AW-1:0] OFS_CTRL1    = 8'h00;
    localparam logic [AW-1:0] OFS_CMPA_CTL = 8'h04;
    localparam logic [AW-1:0] OFS_CMPB_CTL = 8'h08;
    localparam logic [AW-1:0] OFS_CMPA_ADR = 8'h0C;
    localparam logic [AW-1:0] OFS_CMPA_DAT = 8'h10;
    localparam logic [AW-1:0] OFS_CMPB_ADR = 8'h14;
    localparam logic [AW-1:0] OFS_TRACE    = 8'h18;
    localparam logic [AW-1:0] OFS_TSTAT    = 8'h1C;
    localparam logic [AW-1:0] OFS_IRQ_STAT = 8'h20;
    localparam logic [AW-1:0] OFS_IRQ_MASK = 8'h24;

    // debug_control_one bit positions
    localparam int CTL1_ARM    = 0;
    localparam int CTL1_BRK_EN = 1;
    localparam int CTL1_TRACE  = 2;

    // Event bits of the interrupt status and mask registers
    localparam int EV_MATCH_A = 0;
    localparam int EV_MATCH_B = 1;
    localparam int EV_SESSION = 2;
    localparam int EV_WRAP    = 3;
    localparam int EV_W       = 4;

    // Trace line info codes; also the count of increments in a line
    localparam logic [1:0] INFO_BASE  = 2'h0;
    localparam logic [1:0] INFO_ONE   = 2'h1;
    localparam logic [1:0] INFO_THREE = 2'h3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [7:0] CMP_CTL_RST = 8'h00;

    // comparator_match_control layout
    typedef struct packed {
        logic [1:0] spare;
        logic       tag_select;
        logic       immediate_session_end;
        logic       read_select;
        logic       direction_qualify_enable;
        logic       data_mismatch_select;
        logic       comparator_on;
    } dbgct_cmp_ctl_t;

    // One CPU bus cycle
    typedef struct packed {
        logic              valid;
        logic              fetch;
        logic              rd;
        logic [PC_W-1:0]   addr;
        logic [DATA_W-1:0] data;
    } dbgct_bus_t;

    // Opcode entering the execution stage
    typedef struct packed {
        logic            valid;
        logic [PC_W-1:0] pc;
    } dbgct_exec_t;

    typedef struct packed {
        logic [1:0]      info;
        logic [PC_W-1:0] payload;
    } dbgct_line_t;
endpackage : dbgct_pkg

/* File: test/dbgct_checker.sv */
`timescale 1ns/1ps
`default_nettype none

module dbgct_checker #(
    parameter int DEPTH = 64
) (
    input wire logic                   mclk,
    input wire logic                   reset_n,
    input wire dbgct_pkg::dbgct_bus_t  cpu_bus,
    input wire dbgct_pkg::dbgct_exec_t exec_in,
    input wire logic                   awvalid,
    input wire logic                   awready,
    input wire logic                   wvalid,
    input wire logic                   wready,
    input wire logic                   bvalid,
    input wire logic                   arvalid,
    input wire logic                   arready,
    input wire logic                   rvalid,
    input wire logic [1:0]             seq_advance,
    input wire logic                   breakpoint,
    input wire logic                   armed,
    input wire logic                   irq
);
    import dbgct_pkg::*;

    // One domain, so clock and reset are given once
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    // Sequencer steps need a bus cycle or an executed opcode the cycle before
    a_adv_has_cause: assert property (|seq_advance |-> $past(cpu_bus.valid) || $past(exec_in.valid))
        else $error("step without a cause");
    a_adv_needs_arm: assert property (|seq_advance |-> $past(armed))
        else $error("step while disarmed");
    // A break ends the session in the same cycle as its match pulse
    a_brk_disarms: assert property (breakpoint |-> !armed)
        else $error("still armed after a break");
    a_brk_from_match: assert property (breakpoint |-> seq_advance != 2'h0)
        else $error("break without a match");
    a_brk_one_pulse: assert property (breakpoint |=> !breakpoint)
        else $error("break pulse too long");
    a_brk_was_armed: assert property (breakpoint |-> $past(armed))
        else $error("break while disarmed");
    // Bus answers at the latencies the slave promises
    a_wr_answer_two: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("late write answer");
    a_wr_busy_hold: assert property (bvalid |-> !awready && !wready)
        else $error("write reopened early");
    a_rd_answer_one: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("late read answer");

    c_break: cover property (breakpoint);
    c_both_fire: cover property (seq_advance == 2'h3);
    c_traced: cover property (exec_in.valid && armed);
    c_irq: cover property (irq);
endmodule : dbgct_checker

bind dbgct_top dbgct_checker #(.DEPTH(DEPTH)) u_chk (
    .mclk(mclk), .reset_n(reset_n), .cpu_bus(cpu_bus), .exec_in(exec_in),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
    .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .seq_advance(seq_advance),
    .breakpoint(breakpoint), .armed(armed), .irq(irq)
);

`default_nettype wire

/* File: test/dbgct_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none

module dbgct_cpu_model (
    input  wire logic                  mclk,
    output var dbgct_pkg::dbgct_bus_t  cpu_bus,
    output var dbgct_pkg::dbgct_exec_t exec_in
);
    import dbgct_pkg::*;

    // Quiet core at time zero
    initial
    begin
        cpu_bus = '0;
        exec_in = '0;
    end

    // One bus cycle; idle lines then carry the inverse so no stale match survives
    task automatic cyc(input logic f, input logic r, input logic [PC_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        cpu_bus <= '{valid: 1'b1, fetch: f, rd: r, addr: a, data: d};
        @(posedge mclk);
        cpu_bus <= '{valid: 1'b0, fetch: 1'b0, rd: ~r, addr: ~a, data: ~d};
    endtask : cyc

    // Opcode reaches the execution stage for one cycle
    task automatic exe(input logic [PC_W-1:0] pc);
        @(posedge mclk);
        exec_in <= '{valid: 1'b1, pc: pc};
        @(posedge mclk);
        exec_in <= '{valid: 1'b0, pc: ~pc};
    endtask : exe
endmodule : dbgct_cpu_model

`default_nettype wire

/* File: test/tb_debug_comparator_and_pc_trace.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_debug_comparator_and_pc_trace;
    import dbgct_pkg::*;
    localparam int DEP = 8;
    logic             mclk;
    logic             reset_n;
    dbgct_bus_t       cpu_bus;
    dbgct_exec_t      exec_in;
    logic [AW-1:0]    awaddr;
    logic [AW-1:0]    araddr;
    logic             awvalid, awready, wvalid, wready, bvalid, bready;
    logic             arvalid, arready, rvalid, rready, breakpoint, armed, irq;
    logic [31:0]      wdata;
    logic [31:0]      rdata;
    logic [31:0]      v;
    logic [3:0]       wstrb;
    logic [1:0]       bresp;
    logic [1:0]       rresp;
    logic [N_CMP-1:0] seq_advance;
    logic [15:0]      seed;
    logic [19:0]      mem [DEP];
    logic [PC_W-1:0]  pcs [$];
    logic [PC_W-1:0]  recon [$];
    int               err_count, tests_run, cycles;

    dbgct_top #(.DEPTH(DEP)) dut (
        .mclk(mclk), .reset_n(reset_n), .cpu_bus(cpu_bus), .exec_in(exec_in),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .seq_advance(seq_advance), .breakpoint(breakpoint),
        .armed(armed), .irq(irq)
    );
    dbgct_cpu_model cpu (.mclk(mclk), .cpu_bus(cpu_bus), .exec_in(exec_in));

    // 40 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // Hang guard, well above the roughly 1600 cycles the run needs
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_count++;
            conclude();
        end
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge mclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever
        begin
            @(posedge mclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er}, "bresp");
    endtask : wr

    task automatic rd(input logic [AW-1:0] a, output logic [31:0] d, input logic [1:0] er);
        @(posedge mclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever
        begin
            @(posedge mclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        rready <= 1'b0;
        d = rdata;
        chk({30'h0, rresp}, {30'h0, er}, "rresp");
    endtask : rd

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude

    initial
    begin
        logic [PC_W-1:0]   adr, pc;
        logic [DATA_W-1:0] dat, d;
        logic [11:0]       blk, hi;
        logic              ea, eb, hit, seen;
        int                cur, nl, n, st;
        seed = 16'h0027;
        reset_n = 1'b0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = 4'hF;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        // Reset values, read-zero control bits, unmapped place
        rd(OFS_CMPA_CTL, v, RESP_OKAY);
        chk(v, {24'h0, CMP_CTL_RST}, "control reset");
        wr(OFS_CMPA_CTL, 32'h000000FF, RESP_OKAY);
        rd(OFS_CMPA_CTL, v, RESP_OKAY);
        chk(v, 32'h0000003F, "control A");
        wr(OFS_CMPB_CTL, 32'h000000FF, RESP_OKAY);
        rd(OFS_CMPB_CTL, v, RESP_OKAY);
        chk(v, 32'h0000003D, "control B");
        wr(8'h28, 32'h00000001, RESP_SLVERR);
        rd(8'h28, v, RESP_SLVERR);
        chk(v, 32'h0, "unmapped");
        // Every enable, direction, mismatch and data case on both comparators
        wr(OFS_CTRL1, 32'h00000001, RESP_OKAY);
        for (int i = 0; i < 64; i++)
        begin
            seed = lfsr(seed);
            adr = {2'h0, seed};
            dat = seed ^ 16'hA5C3;
            wr(OFS_CMPA_CTL, {28'h0, i[3:0]}, RESP_OKAY);
            wr(OFS_CMPB_CTL, {28'h0, i[3:0]}, RESP_OKAY);
            wr(OFS_CMPA_ADR, {14'h0, adr}, RESP_OKAY);
            wr(OFS_CMPB_ADR, {14'h0, adr}, RESP_OKAY);
            wr(OFS_CMPA_DAT, {16'h0, dat}, RESP_OKAY);
            hit = ~seed[9];
            d = i[5] ? dat : ~dat;
            eb = i[0] && hit && (!i[2] || i[3] == i[4]);
            ea = eb && ((d == dat) != i[1]);
            cpu.cyc(1'b0, i[4], hit ? adr : ~adr, d);
            #1;
            chk({30'h0, seq_advance}, {30'h0, eb, ea}, "match pair");
        end
        // Break channel without, then with, module breakpoint enable
        wr(OFS_CMPB_CTL, 32'h0, RESP_OKAY);
        wr(OFS_CMPA_CTL, 32'h00000011, RESP_OKAY);
        cpu.cyc(1'b0, 1'b0, adr, dat);
        #1;
        chk({31'h0, breakpoint}, 32'h0, "break disabled");
        wr(OFS_IRQ_STAT, 32'h0000000F, RESP_OKAY);
        wr(OFS_CTRL1, 32'h00000003, RESP_OKAY);
        wr(OFS_IRQ_MASK, 32'h00000004, RESP_OKAY);
        cpu.cyc(1'b0, 1'b1, adr, dat);
        #1;
        chk({28'h0, seq_advance, breakpoint, armed}, 32'h00000006, "break");
        @(posedge mclk);
        #1;
        chk({31'h0, irq}, 32'h1, "irq raised");
        rd(OFS_IRQ_STAT, v, RESP_OKAY);
        chk(v, 32'h00000005, "status");
        wr(OFS_IRQ_STAT, 32'h00000004, RESP_OKAY);
        #1;
        chk({31'h0, irq}, 32'h0, "irq masked");
        // Tag mode: fetch only marks, execution fires; qualifiers ignored
        wr(OFS_CTRL1, 32'h00000001, RESP_OKAY);
        wr(OFS_CMPA_CTL, 32'h0000002F, RESP_OKAY);
        cpu.cyc(1'b1, 1'b0, adr, ~dat);
        #1;
        chk({30'h0, seq_advance}, 32'h0, "tag fetch");
        cpu.exe(adr);
        #1;
        chk({30'h0, seq_advance}, 32'h1, "tag exec");
        // Compressed trace with wrap-around, modelled line by line
        wr(OFS_CMPA_CTL, 32'h0, RESP_OKAY);
        wr(OFS_CTRL1, 32'h0, RESP_OKAY);
        wr(OFS_CTRL1, 32'h00000005, RESP_OKAY);
        rd(OFS_TRACE, v, RESP_OKAY);
        chk(v, 32'h0, "locked trace");
        nl = 0;
        cur = 0;
        hi = '0;
        for (int k = 0; k < 40; k++)
        begin
            seed = lfsr(seed);
            if (k == 0 || seed[2:0] == 3'h0)
                blk = seed[15:4];
            pc = {blk, seed[8:3]};
            n = (k == 0) ? 0 : int'(mem[cur][19:18]);
            if (k == 0 || blk != hi || n == 0 || n == 3)
            begin
                cur = (k == 0) ? 0 : (cur + 1) % DEP;
                nl++;
                if (k == 0 || blk != hi || cur == 0)
                begin
                    mem[cur] = {INFO_BASE, pc};
                    hi = blk;
                end
                else
                    mem[cur] = {INFO_ONE, 12'h0, pc[5:0]};
            end
            else
            begin
                mem[cur][6 * n +: 6] = pc[5:0];
                mem[cur][19:18] = 2'(n + 1);
            end
            pcs.push_back(pc);
            cpu.exe(pc);
        end
        wr(OFS_CTRL1, 32'h0, RESP_OKAY);
        rd(OFS_TRACE + 8'h01, v, RESP_OKAY);
        chk(v, 32'h0, "misaligned");
        st = (nl > DEP) ? (cur + 1) % DEP : 0;
        seen = 1'b0;
        for (int j = 0; j < ((nl > DEP) ? DEP : nl); j++)
        begin
            rd(OFS_TRACE, v, RESP_OKAY);
            chk(v, {12'h0, mem[(st + j) % DEP]}, "trace line");
            if (v[19:18] == INFO_BASE)
            begin
                seen = 1'b1;
                hi = v[17:6];
                recon.push_back(v[17:0]);
            end
            else if (seen)
                for (int m = 0; m < int'(v[19:18]); m++)
                    recon.push_back({hi, v[6 * m +: 6]});
        end
        for (int j = 0; j < recon.size(); j++)
            chk({14'h0, recon[j]}, {14'h0, pcs[pcs.size() - recon.size() + j]}, "flow");
        conclude();
    end
endmodule : tb_debug_comparator_and_pc_trace

`default_nettype wire
